//--- dv/pwt_timer_tb_top.sv
// Self-checking bench for the pulse width timer
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
	err_total++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end

module pwt_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pwt_pkg::*;

	logic                          core_clk;
	logic                          rst_b;
	logic                          counter_enable;
	logic                          counter_reset;
	logic                          pwm_enable;
	logic                          count_src_sel;
	pwt_count_mode_type            count_mode;
	logic [31:0]                   prescale_max;
	logic [6:0][31:0]              match_value;
	pwt_match_ctrl_type [6:0]      match_ctrl;
	logic [6:0]                    match_release;
	logic [6:0]                    double_edge;
	logic [6:0]                    match_flag_clear;
	logic [6:0]                    match_flag;
	logic [6:0]                    pwm_out;
	logic [1:0]                    cap_pin;
	logic [1:0]                    cap_flag_clear;
	logic [1:0]                    cap_flag;
	pwt_cap_ctrl_type [1:0]        cap_ctrl;
	logic [31:0]                   timer_count;
	logic [31:0]                   prescale_count;
	logic                          timer_halted;
	logic                          irq;
	logic [1:0][31:0]              capture_value;
	int                            err_total;
	int                            check_count;
	logic [31:0]                   cur [7];
	logic [31:0]                   pnd [7];
	logic                          dbl;
	logic [4:0]                    mask;

	pwt_timer pwt_timer_i (
		.core_clk(core_clk), .rst_b(rst_b),
		.counter_enable(counter_enable), .counter_reset(counter_reset),
		.pwm_enable(pwm_enable), .count_mode(count_mode),
		.count_src_sel(count_src_sel), .prescale_max(prescale_max),
		.match_value(match_value), .match_ctrl(match_ctrl),
		.match_release(match_release), .double_edge(double_edge),
		.cap_pin(cap_pin), .cap_ctrl(cap_ctrl),
		.match_flag_clear(match_flag_clear),
		.cap_flag_clear(cap_flag_clear), .timer_count(timer_count),
		.prescale_count(prescale_count), .timer_halted(timer_halted),
		.capture_value(capture_value), .match_flag(match_flag),
		.cap_flag(cap_flag), .irq(irq), .pwm_out(pwm_out)
	);

	always #20 core_clk = ~core_clk;

	task automatic conclude();
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Bounded wait, sampled mid-cycle so counts have settled
	task automatic wait_tc(input logic [31:0] v);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (timer_count !== v && n < 100);
		`CHK("timer_count", v, timer_count)
	endtask

	task automatic rel(input int i, input logic [31:0] v);
		@(posedge core_clk);
		match_value[i] <= v;
		match_release[i] <= 1'b1;
		pnd[i] = v;
		@(posedge core_clk);
		match_release <= '0;
	endtask

	function automatic logic exp_out(input int k);
		logic [31:0] t;
		t = timer_count;
		if (k == 3 && dbl)
			return (cur[3] < cur[2]) ? !(t > cur[3] && t <= cur[2])
				: (t > cur[2] && t <= cur[3]);
		return cur[k] != 0 && t <= cur[k];
	endfunction

	// Released values become active only where the count restarts
	task automatic chk(input int n);
		repeat (n) begin
			@(negedge core_clk);
			if (timer_count === 32'h0)
				cur = pnd;
			`CHK("pwm_out0", 1'b0, pwm_out[0])
			for (int k = 1; k < 5; k++)
				if (mask[k]) `CHK("pwm_out", exp_out(k), pwm_out[k])
		end
	endtask

	task automatic t_prescale();
		@(posedge core_clk);
		prescale_max <= 32'h2;
		counter_enable <= 1'b1;
		counter_reset <= 1'b0;
		for (int k = 0; k < 9; k++) begin
			@(negedge core_clk);
			`CHK("prescale_count", k % 3, prescale_count)
			`CHK("timer_count", k / 3, timer_count)
		end
		`CHK("pwm_out", 7'h0, pwm_out)
	endtask

	task automatic t_match();
		logic [31:0] t;
		@(posedge core_clk);
		counter_reset <= 1'b1;
		prescale_max <= 32'h0;
		match_ctrl[5] <= 3'b110;
		match_flag_clear <= 7'h7f;
		rel(5, 32'h5);
		@(posedge core_clk);
		counter_reset <= 1'b0;
		// Clear once more while the count is still zero, after the old value stopped matching
		@(posedge core_clk);
		match_flag_clear <= 7'h0;
		wait_tc(32'h5);
		`CHK("irq", 1'b0, irq)
		cyc(1);
		`CHK("timer_count", 32'h0, timer_count)
		`CHK("match_flag5", 1'b1, match_flag[5])
		cyc(1);
		`CHK("irq", 1'b1, irq)
		@(posedge core_clk);
		match_flag_clear <= 7'h20;
		@(posedge core_clk);
		match_flag_clear <= 7'h0;
		cyc(2);
		`CHK("match_flag5", 1'b0, match_flag[5])
		`CHK("irq", 1'b0, irq)
		@(posedge core_clk);
		match_ctrl[5] <= 3'b001;
		wait_tc(32'h5);
		cyc(2);
		t = timer_count;
		`CHK("timer_halted", 1'b1, timer_halted)
		cyc(4);
		`CHK("timer_count", t, timer_count)
		@(posedge core_clk);
		counter_enable <= 1'b0;
		cyc(2);
		`CHK("timer_halted", 1'b0, timer_halted)
	endtask

	task automatic t_pwm();
		@(posedge core_clk);
		counter_reset <= 1'b1;
		counter_enable <= 1'b1;
		match_ctrl <= '0;
		rel(0, 32'h9);
		rel(1, 32'h4);
		rel(2, 32'h0);
		rel(3, 32'h6);
		rel(4, 32'h7);
		cur = pnd;
		@(posedge core_clk);
		counter_reset <= 1'b0;
		pwm_enable <= 1'b1;
		mask = 5'b11110;
		wait_tc(32'h9);
		wait_tc(32'h0);
		chk(10);
		wait_tc(32'h2);
		rel(1, 32'h6);
		// Changed but never released, so it must be ignored
		@(posedge core_clk);
		match_value[4] <= 32'h2;
		chk(15);
	endtask

	task automatic t_dbl();
		@(posedge core_clk);
		double_edge <= 7'h08;
		dbl = 1'b1;
		for (int s = 0; s < 2; s++) begin
			rel(2, s ? 32'h6 : 32'h2);
			rel(3, s ? 32'h2 : 32'h6);
			mask = 5'b0;
			chk(20);
			mask = 5'b01010;
			chk(10);
		end
	endtask

	task automatic t_cap();
		logic [31:0] t;
		@(posedge core_clk);
		pwm_enable <= 1'b0;
		cap_ctrl[0] <= 3'b101;
		@(posedge core_clk);
		cap_pin[0] <= 1'b1;
		cyc(1);
		t = timer_count + 32'h3;
		cyc(5);
		`CHK("capture_value", t, capture_value[0])
		`CHK("cap_flag", 1'b1, cap_flag[0])
		`CHK("irq", 1'b1, irq)
		@(posedge core_clk);
		cap_pin[0] <= 1'b0;
		cap_flag_clear <= 2'h1;
		@(posedge core_clk);
		cap_flag_clear <= 2'h0;
		cyc(8);
		`CHK("capture_value", t, capture_value[0])
		`CHK("cap_flag", 1'b0, cap_flag[0])
	endtask

	task automatic t_ext();
		for (int m = 1; m < 4; m++) begin
			@(posedge core_clk);
			count_mode <= pwt_count_mode_type'(2'(m));
			count_src_sel <= 1'b1;
			counter_reset <= 1'b1;
			@(posedge core_clk);
			counter_reset <= 1'b0;
			repeat (4) begin
				@(posedge core_clk);
				cap_pin[1] <= 1'b1;
				cyc(4);
				@(posedge core_clk);
				cap_pin[1] <= 1'b0;
				cyc(4);
			end
			cyc(4);
			`CHK("timer_count", m == 3 ? 8 : 4, timer_count)
		end
	endtask

	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		counter_enable = 1'b0;
		counter_reset = 1'b1;
		pwm_enable = 1'b0;
		count_src_sel = 1'b0;
		count_mode = PWT_MODE_TIMER;
		prescale_max = '0;
		match_value = '0;
		match_ctrl = '0;
		match_release = '0;
		double_edge = '0;
		match_flag_clear = '0;
		cap_pin = '0;
		cap_flag_clear = '0;
		cap_ctrl = '0;
		err_total = 0;
		check_count = 0;
		dbl = 1'b0;
		mask = '0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		t_prescale();
		t_match();
		t_pwm();
		t_dbl();
		t_cap();
		t_ext();
		conclude();
	end

	// The full sequence takes well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		conclude();
	end
endmodule

//--- rtl/pwt_cfg.svh
// Reset values and fixed sizes for the pulse width timer
`ifndef PWT_CFG_SVH
`define PWT_CFG_SVH
`define PWT_NUM_MATCH   7
`define PWT_NUM_CAP     2
`define PWT_CNT_W       32
`define PWT_SYNC_DEPTH  3
`define PWT_RST_COUNT   32'h0000_0000
`define PWT_RST_PWM     1'b0
`define PWT_PERIOD_IDX  0
`endif

//--- rtl/pwt_pkg.sv
// Types shared by the pulse width timer
package pwt_pkg;
	typedef enum logic [1:0] {
		PWT_MODE_TIMER = 2'h0,
		PWT_MODE_RISE  = 2'h1,
		PWT_MODE_FALL  = 2'h2,
		PWT_MODE_BOTH  = 2'h3
	} pwt_count_mode_type;

	typedef struct packed {
		logic irq_en;
		logic reset_en;
		logic stop_en;
	} pwt_match_ctrl_type;

	typedef struct packed {
		logic on_rise;
		logic on_fall;
		logic irq_en;
	} pwt_cap_ctrl_type;
endpackage

//--- rtl/pwt_timer.sv
// Timer/counter with prescaler, capture and multi-output pulse width logic
// Summary of operation
// - Seven match registers compare against the count for outputs and events.
// - Count clears when it equals the cycle period match value.
// - Single-edge output falls at the count of its own match register.
// - All single-edge outputs with a nonzero match value rise together at the cycle period match.
// - Each extra single-edge output uses just one more match register.
// - Double-edge output takes rise and fall from two match registers.
// - Rise before fall gives positive pulse; reversed gives negative pulse.
// - Thirty-two bit counter fed through a programmable 32-bit prescaler.
// - Counter counts clock cycles or edges of an external count input.
// - Per match: continue, stop or reset timer, each with optional interrupt.
// - Capture input transition latches the count, optional interrupt.
// - Single-edge output programmed constant low never rises.
// - Match values apply only after release, at the cycle boundary in pulse mode.
// - With pulse mode off the block is a plain timer/counter.
`include "pwt_cfg.svh"

module pwt_timer #(
	parameter int NUM_MATCH = `PWT_NUM_MATCH,
	parameter int NUM_CAP   = `PWT_NUM_CAP,
	parameter int CNT_W     = `PWT_CNT_W
) (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst_b,
	// Counter control
	input  wire logic                         counter_enable,
	input  wire logic                         counter_reset,
	input  wire logic                         pwm_enable,
	input  wire pwt_pkg::pwt_count_mode_type  count_mode,
	input  wire logic                         count_src_sel,
	input  wire logic [CNT_W-1:0]             prescale_max,
	// Match setup
	input  wire logic [NUM_MATCH-1:0][CNT_W-1:0] match_value,
	input  wire pwt_pkg::pwt_match_ctrl_type [NUM_MATCH-1:0] match_ctrl,
	input  wire logic [NUM_MATCH-1:0]         match_release,
	input  wire logic [NUM_MATCH-1:0]         double_edge,
	// Capture setup and pins
	input  wire logic [NUM_CAP-1:0]           cap_pin,
	input  wire pwt_pkg::pwt_cap_ctrl_type [NUM_CAP-1:0] cap_ctrl,
	// Flag clears, one-cycle pulses
	input  wire logic [NUM_MATCH-1:0]         match_flag_clear,
	input  wire logic [NUM_CAP-1:0]           cap_flag_clear,
	// Status
	output logic [CNT_W-1:0]                  timer_count,
	output logic [CNT_W-1:0]                  prescale_count,
	output logic                              timer_halted,
	output logic [NUM_CAP-1:0][CNT_W-1:0]     capture_value,
	output logic [NUM_MATCH-1:0]              match_flag,
	output logic [NUM_CAP-1:0]                cap_flag,
	output logic                              irq,
	// Pulse outputs, index 0 unused and held low
	output logic [NUM_MATCH-1:0]              pwm_out
);
	import pwt_pkg::*;

	initial begin
		if (NUM_MATCH < 4 || NUM_CAP < 1 || CNT_W < 2)
			$error("pwt_timer: unsupported parameter values");
	end

	// Pin synchronisers; a change counts once stages two and three agree
	logic [NUM_CAP-1:0] sync1;
	logic [NUM_CAP-1:0] sync2;
	logic [NUM_CAP-1:0] sync3;
	logic [NUM_CAP-1:0] cap_lvl;
	logic [NUM_CAP-1:0] next_cap_lvl;
	logic [NUM_CAP-1:0] cap_rise;
	logic [NUM_CAP-1:0] cap_fall;
	logic [NUM_CAP-1:0] cap_ev;

	always_comb begin
		next_cap_lvl = cap_lvl;
		cap_rise     = '0;
		cap_fall     = '0;
		for (int i = 0; i < NUM_CAP; i++) begin
			if (sync2[i] == sync3[i]) begin
				next_cap_lvl[i] = sync3[i];
				cap_rise[i]     = sync3[i] & ~cap_lvl[i];
				cap_fall[i]     = ~sync3[i] & cap_lvl[i];
			end
		end
		for (int i = 0; i < NUM_CAP; i++)
			cap_ev[i] = (cap_rise[i] & cap_ctrl[i].on_rise) |
				(cap_fall[i] & cap_ctrl[i].on_fall);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1   <= '0;
			sync2   <= '0;
			sync3   <= '0;
			cap_lvl <= '0;
		end else begin
			sync1   <= cap_pin;
			sync2   <= sync1;
			sync3   <= sync2;
			cap_lvl <= next_cap_lvl;
		end
	end

	// Count source: clock cycles or edges of the chosen input
	logic src_rise;
	logic src_fall;
	logic advance;
	logic tick;

	always_comb begin
		src_rise = cap_rise[count_src_sel];
		src_fall = cap_fall[count_src_sel];
		unique case (count_mode)
			PWT_MODE_TIMER: advance = 1'b1;
			PWT_MODE_RISE:  advance = src_rise;
			PWT_MODE_FALL:  advance = src_fall;
			PWT_MODE_BOTH:  advance = src_rise | src_fall;
		endcase
		advance = advance & counter_enable & ~timer_halted;
		tick = advance && (prescale_count == prescale_max);
	end

	// Released match values, loaded at the cycle boundary in pulse mode
	logic [NUM_MATCH-1:0][CNT_W-1:0] active_match;
	logic [NUM_MATCH-1:0][CNT_W-1:0] next_active_match;
	logic [NUM_MATCH-1:0]            pending;
	logic [NUM_MATCH-1:0]            next_pending;
	logic [NUM_MATCH-1:0]            mev;
	logic                            any_reset;
	logic                            any_stop;
	logic                            apply;

	always_comb begin
		any_reset = 1'b0;
		any_stop  = 1'b0;
		for (int i = 0; i < NUM_MATCH; i++) begin
			mev[i] = tick && (timer_count == active_match[i]);
			if (mev[i] && match_ctrl[i].reset_en)
				any_reset = 1'b1;
			if (mev[i] && match_ctrl[i].stop_en)
				any_stop = 1'b1;
		end
		if (pwm_enable && mev[`PWT_PERIOD_IDX])
			any_reset = 1'b1;
		// Outside pulse mode no cycle exists, so values load at once
		apply = ~pwm_enable | mev[`PWT_PERIOD_IDX];
		next_active_match = active_match;
		for (int i = 0; i < NUM_MATCH; i++)
			if (apply && pending[i])
				next_active_match[i] = match_value[i];
		// A release landing on an apply cycle stays pending: harmless
		next_pending = (pending & ~{NUM_MATCH{apply}}) | match_release;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_match <= '0;
			pending      <= '0;
		end else begin
			active_match <= next_active_match;
			pending      <= next_pending;
		end
	end

	// Prescaler, counter and stop latch
	logic [CNT_W-1:0] next_timer_count;
	logic [CNT_W-1:0] next_prescale_count;
	logic             next_timer_halted;

	always_comb begin
		next_timer_count    = timer_count;
		next_prescale_count = prescale_count;
		next_timer_halted   = timer_halted & counter_enable;
		if (counter_reset) begin
			next_timer_count    = `PWT_RST_COUNT;
			next_prescale_count = `PWT_RST_COUNT;
		end else if (advance) begin
			if (tick) begin
				next_prescale_count = `PWT_RST_COUNT;
				if (any_reset)
					next_timer_count = `PWT_RST_COUNT;
				else
					next_timer_count = timer_count + 1'b1;
			end else begin
				next_prescale_count = prescale_count + 1'b1;
			end
		end
		if (any_stop)
			next_timer_halted = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_count    <= `PWT_RST_COUNT;
			prescale_count <= `PWT_RST_COUNT;
			timer_halted   <= 1'b0;
		end else begin
			timer_count    <= next_timer_count;
			prescale_count <= next_prescale_count;
			timer_halted   <= next_timer_halted;
		end
	end

	// Captures and sticky flags; a new event beats a clear
	logic [NUM_CAP-1:0][CNT_W-1:0] next_capture_value;
	logic [NUM_MATCH-1:0]          next_match_flag;
	logic [NUM_CAP-1:0]            next_cap_flag;
	logic                          next_irq;

	always_comb begin
		next_capture_value = capture_value;
		for (int i = 0; i < NUM_CAP; i++)
			if (cap_ev[i])
				next_capture_value[i] = timer_count;
		next_match_flag = (match_flag & ~match_flag_clear) | mev;
		next_cap_flag   = (cap_flag & ~cap_flag_clear) | cap_ev;
		next_irq = 1'b0;
		for (int i = 0; i < NUM_MATCH; i++)
			next_irq = next_irq |
				(next_match_flag[i] & match_ctrl[i].irq_en);
		for (int i = 0; i < NUM_CAP; i++)
			next_irq = next_irq |
				(next_cap_flag[i] & cap_ctrl[i].irq_en);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			capture_value <= '0;
			match_flag    <= '0;
			cap_flag      <= '0;
			irq           <= 1'b0;
		end else begin
			capture_value <= next_capture_value;
			match_flag    <= next_match_flag;
			cap_flag      <= next_cap_flag;
			irq           <= next_irq;
		end
	end

	// Pulse outputs; a fall coinciding with a rise wins
	logic [NUM_MATCH-1:0] next_pwm_out;
	logic [NUM_MATCH-1:0] set_ev;

	always_comb begin
		next_pwm_out = pwm_out;
		set_ev       = '0;
		for (int n = 1; n < NUM_MATCH; n++) begin
			if (double_edge[n] && n >= 2)
				set_ev[n] = mev[n-1];
			else
				// Zero in the edge register means constant low
				set_ev[n] = mev[`PWT_PERIOD_IDX] &&
					(active_match[n] != '0);
			if (mev[n])
				next_pwm_out[n] = 1'b0;
			else if (set_ev[n])
				next_pwm_out[n] = 1'b1;
		end
		next_pwm_out[0] = 1'b0;
		if (!pwm_enable)
			next_pwm_out = '0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pwm_out <= '0;
		else
			pwm_out <= next_pwm_out;
	end

	// Checks
	property p_period_clear;
		@(posedge core_clk) disable iff (!rst_b)
		pwm_enable && mev[0] |=> timer_count == '0;
	endproperty
	a_period_clear: assert property (p_period_clear)
		else $error("count not cleared at period match");

	property p_count_step;
		@(posedge core_clk) disable iff (!rst_b)
		tick && !any_reset && !counter_reset
			|=> timer_count == $past(timer_count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step on prescaler wrap");

	property p_presc_wrap;
		@(posedge core_clk) disable iff (!rst_b)
		tick |=> prescale_count == '0;
	endproperty
	a_presc_wrap: assert property (p_presc_wrap)
		else $error("prescaler did not restart");

	property p_single_rise;
		@(posedge core_clk) disable iff (!rst_b)
		pwm_enable && mev[0] && !mev[1] && active_match[1] != '0
			|=> pwm_out[1];
	endproperty
	a_single_rise: assert property (p_single_rise)
		else $error("single-edge output missed cycle rise");

	property p_single_fall;
		@(posedge core_clk) disable iff (!rst_b)
		mev[1] |=> !pwm_out[1];
	endproperty
	a_single_fall: assert property (p_single_fall)
		else $error("single-edge output missed its fall");

	property p_const_low;
		@(posedge core_clk) disable iff (!rst_b)
		!double_edge[2] && active_match[2] == '0 && !pwm_out[2]
			|=> !pwm_out[2];
	endproperty
	a_const_low: assert property (p_const_low)
		else $error("constant low output rose");

	property p_double_edges;
		@(posedge core_clk) disable iff (!rst_b)
		pwm_enable && double_edge[3] && mev[2] && !mev[3]
			|=> pwm_out[3];
	endproperty
	a_double_edges: assert property (p_double_edges)
		else $error("double-edge output missed its rise");

	property p_hold_values;
		@(posedge core_clk) disable iff (!rst_b)
		pwm_enable && !mev[0] ##1 1'b1 |-> $stable(active_match);
	endproperty
	a_hold_values: assert property (p_hold_values)
		else $error("match value changed mid-cycle");

	property p_stop;
		@(posedge core_clk) disable iff (!rst_b)
		any_stop |=> timer_halted;
	endproperty
	a_stop: assert property (p_stop)
		else $error("timer did not stop on match");

	property p_capture;
		@(posedge core_clk) disable iff (!rst_b)
		cap_ev[0] |=> capture_value[0] == $past(timer_count)
			&& cap_flag[0];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture missed the count");

	property p_flag_irq;
		@(posedge core_clk) disable iff (!rst_b)
		mev[NUM_MATCH-2] && match_ctrl[NUM_MATCH-2].irq_en
			|=> match_flag[NUM_MATCH-2] && irq;
	endproperty
	a_flag_irq: assert property (p_flag_irq)
		else $error("match flag or interrupt missing");

	property p_plain_timer;
		@(posedge core_clk) disable iff (!rst_b)
		!pwm_enable |=> pwm_out == '0;
	endproperty
	a_plain_timer: assert property (p_plain_timer)
		else $error("pulse output active outside pulse mode");

	c_period: cover property (@(posedge core_clk) disable iff (!rst_b)
		pwm_enable && mev[0]);
	c_neg_pulse: cover property (@(posedge core_clk) disable iff (!rst_b)
		double_edge[3] && $fell(pwm_out[3]));
	c_capture: cover property (@(posedge core_clk) disable iff (!rst_b)
		cap_ev[0]);
endmodule
